// [hw/dhwio_bank.v]
// drive hardware information bank: eeprom size, operating conditions,
// hardware configuration word and special drive mode selection, as a classic wishbone slave
// assumes all inputs synchronous to clk_sys_in and measurement inputs already in final units
`timescale 1ns/1ps
`default_nettype none
`include "dhwio_regs.vh"

module dhwio_bank #(
	parameter ROTARY_W = 4
) (
	input wire clk_sys_in,
	input wire reset_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [`DHWIO_ADR_W-1:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	input wire [31:0] eeprom_byte_capacity_in,
	input wire [31:0] power_stage_supply_mv_in,
	input wire [31:0] logic_supply_mv_in,
	input wire [31:0] board_temperature_in,
	input wire [ROTARY_W-1:0] rotary_switch_in,
	output reg [31:0] hw_config_out,
	output reg special_modes_enable_out,
	output reg [7:0] special_mode_select_out
);

	wire [31:0] eeprom_cap_ff;
	wire [31:0] supply_mv_ff;
	wire [31:0] logic_mv_ff;
	wire [31:0] board_temp_ff;
	wire [31:0] hw_config_ff;
	wire [7:0] mode_cfg_ff;
	wire [7:0] vswitch_ff;

	reg [31:0] nxt_rdata;
	reg nxt_enable;
	reg [7:0] nxt_select;

	wire [`DHWIO_WADR_W-1:0] word_adr;
	wire [15:0] obj_idx;
	wire [7:0] sub_idx;
	wire bus_req;
	wire wr_stb;
	wire [7:0] rotary_ext;

	assign word_adr = wb_adr_in[`DHWIO_ADR_W-1:2];
	assign obj_idx = word_adr[23:8];
	assign sub_idx = word_adr[7:0];
	// one access per request; the ack cycle itself does not start a second one
	assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign wr_stb = bus_req & wb_we_in;
	assign rotary_ext = {{(8-ROTARY_W){1'b0}}, rotary_switch_in};

	wire hit_hw_config;
	wire hit_mode_cfg;
	wire hit_vswitch;

	assign hit_hw_config = (obj_idx == `DHWIO_OBJ_HW_CONFIG) && (sub_idx == `DHWIO_SUB_HW_CONFIG);
	assign hit_mode_cfg = (obj_idx == `DHWIO_OBJ_SPECIAL) && (sub_idx == `DHWIO_SUB_MODE_CFG);
	assign hit_vswitch = (obj_idx == `DHWIO_OBJ_SPECIAL) && (sub_idx == `DHWIO_SUB_VSWITCH);

	// writes: byte lanes honoured, narrow entries take lane 0 only
	dhwio_lane_reg #(
		.LANES(4),
		.RESET_VALUE(`DHWIO_RST_HW_CONFIG)
	) u_hw_config (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.write_in(wr_stb && hit_hw_config),
		.lane_sel_in(wb_sel_in),
		.data_in(wb_dat_in),
		.value_out(hw_config_ff)
	);

	dhwio_lane_reg #(
		.LANES(1),
		.RESET_VALUE(`DHWIO_RST_MODE_CFG)
	) u_mode_cfg (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.write_in(wr_stb && hit_mode_cfg),
		.lane_sel_in(wb_sel_in[0]),
		.data_in(wb_dat_in[7:0]),
		.value_out(mode_cfg_ff)
	);

	dhwio_lane_reg #(
		.LANES(1),
		.RESET_VALUE(`DHWIO_RST_VSWITCH)
	) u_vswitch (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.write_in(wr_stb && hit_vswitch),
		.lane_sel_in(wb_sel_in[0]),
		.data_in(wb_dat_in[7:0]),
		.value_out(vswitch_ff)
	);

	// read multiplexer; unmapped addresses read zero
	always @* begin
		nxt_rdata = 32'h00000000;
		case (obj_idx)
			`DHWIO_OBJ_HW_INFO: begin
				case (sub_idx)
					`DHWIO_SUB_COUNT: nxt_rdata = {24'h000000, `DHWIO_CNT_HW_INFO};
					`DHWIO_SUB_EEPROM_CAP: nxt_rdata = eeprom_cap_ff;
					default: nxt_rdata = 32'h00000000;
				endcase
			end
			`DHWIO_OBJ_HW_CONFIG: begin
				case (sub_idx)
					`DHWIO_SUB_COUNT: nxt_rdata = {24'h000000, `DHWIO_CNT_HW_CONFIG};
					`DHWIO_SUB_HW_CONFIG: nxt_rdata = hw_config_ff;
					default: nxt_rdata = 32'h00000000;
				endcase
			end
			`DHWIO_OBJ_OPER_COND: begin
				case (sub_idx)
					`DHWIO_SUB_COUNT: nxt_rdata = {24'h000000, `DHWIO_CNT_OPER_COND};
					`DHWIO_SUB_SUPPLY_MV: nxt_rdata = supply_mv_ff;
					`DHWIO_SUB_LOGIC_MV: nxt_rdata = logic_mv_ff;
					`DHWIO_SUB_BOARD_TEMP: nxt_rdata = board_temp_ff;
					`DHWIO_SUB_MOTOR_TEMP: nxt_rdata = `DHWIO_RST_COND;
					`DHWIO_SUB_CHIP_TEMP: nxt_rdata = `DHWIO_RST_COND;
					default: nxt_rdata = 32'h00000000;
				endcase
			end
			`DHWIO_OBJ_SPECIAL: begin
				case (sub_idx)
					`DHWIO_SUB_COUNT: nxt_rdata = {24'h000000, `DHWIO_CNT_SPECIAL};
					`DHWIO_SUB_MODE_CFG: nxt_rdata = {24'h000000, mode_cfg_ff};
					`DHWIO_SUB_VSWITCH: nxt_rdata = {24'h000000, vswitch_ff};
					default: nxt_rdata = 32'h00000000;
				endcase
			end
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// mode source selection from the stored configuration
	always @* begin
		nxt_enable = 1'b0;
		nxt_select = 8'h00;
		case (mode_cfg_ff)
			`DHWIO_MODE_OFF: begin
				nxt_enable = 1'b0;
				nxt_select = 8'h00;
			end
			`DHWIO_MODE_ROTARY: begin
				nxt_enable = 1'b1;
				nxt_select = rotary_ext;
			end
			`DHWIO_MODE_VIRTUAL: begin
				nxt_enable = 1'b1;
				nxt_select = vswitch_ff;
			end
			default: begin
				nxt_enable = 1'b0;
				nxt_select = 8'h00;
			end
		endcase
	end

	// measured values are captured every cycle; writes to them are dropped
	dhwio_capture_reg #(
		.WIDTH(32),
		.RESET_VALUE(`DHWIO_RST_EEPROM_CAP)
	) u_eeprom_cap (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.value_in(eeprom_byte_capacity_in),
		.value_out(eeprom_cap_ff)
	);

	dhwio_capture_reg #(
		.WIDTH(32),
		.RESET_VALUE(`DHWIO_RST_COND)
	) u_supply_mv (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.value_in(power_stage_supply_mv_in),
		.value_out(supply_mv_ff)
	);

	dhwio_capture_reg #(
		.WIDTH(32),
		.RESET_VALUE(`DHWIO_RST_COND)
	) u_logic_mv (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.value_in(logic_supply_mv_in),
		.value_out(logic_mv_ff)
	);

	dhwio_capture_reg #(
		.WIDTH(32),
		.RESET_VALUE(`DHWIO_RST_COND)
	) u_board_temp (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.value_in(board_temperature_in),
		.value_out(board_temp_ff)
	);

	// bus answer one cycle after the request, data registered with it
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= bus_req;
			if (bus_req && !wb_we_in) begin
				wb_dat_out <= nxt_rdata;
			end
		end
	end

	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			hw_config_out <= `DHWIO_RST_HW_CONFIG;
			special_modes_enable_out <= 1'b0;
			special_mode_select_out <= 8'h00;
		end else begin
			hw_config_out <= hw_config_ff;
			special_modes_enable_out <= nxt_enable;
			special_mode_select_out <= nxt_select;
		end
	end

endmodule

// one measured value, refreshed every cycle; host writes never reach it
module dhwio_capture_reg #(
	parameter WIDTH = 32,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input wire clk_sys_in,
	input wire reset_in,
	input wire [WIDTH-1:0] value_in,
	output wire [WIDTH-1:0] value_out
);

	reg [WIDTH-1:0] value_ff;

	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			value_ff <= RESET_VALUE;
		end else begin
			value_ff <= value_in;
		end
	end

	assign value_out = value_ff;

endmodule

// host-writable register of whole byte lanes; a lane changes only when its select bit is set
module dhwio_lane_reg #(
	parameter LANES = 4,
	parameter [8*LANES-1:0] RESET_VALUE = {(8*LANES){1'b0}}
) (
	input wire clk_sys_in,
	input wire reset_in,
	input wire write_in,
	input wire [LANES-1:0] lane_sel_in,
	input wire [8*LANES-1:0] data_in,
	output wire [8*LANES-1:0] value_out
);

	reg [8*LANES-1:0] value_ff;
	reg [8*LANES-1:0] nxt_value;
	integer lane;

	always @* begin
		nxt_value = value_ff;
		for (lane = 0; lane < LANES; lane = lane + 1) begin
			if (write_in && lane_sel_in[lane]) begin
				nxt_value[8*lane +: 8] = data_in[8*lane +: 8];
			end
		end
	end

	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			value_ff <= RESET_VALUE;
		end else begin
			value_ff <= nxt_value;
		end
	end

	assign value_out = value_ff;

endmodule

`default_nettype wire

// [hw/dhwio_regs.vh]
// register map, reset values and field codes of the drive hardware information bank
// assumes a word-addressed view: word address = {object index, subindex}, byte address = word * 4
`ifndef DHWIO_REGS_VH
`define DHWIO_REGS_VH

`define DHWIO_ADR_W 26
`define DHWIO_WADR_W 24

// object indices
`define DHWIO_OBJ_HW_INFO 16'h4012
`define DHWIO_OBJ_HW_CONFIG 16'h4013
`define DHWIO_OBJ_OPER_COND 16'h4014
`define DHWIO_OBJ_SPECIAL 16'h4015

// subindices
`define DHWIO_SUB_COUNT 8'h00
`define DHWIO_SUB_EEPROM_CAP 8'h01
`define DHWIO_SUB_HW_CONFIG 8'h01
`define DHWIO_SUB_SUPPLY_MV 8'h01
`define DHWIO_SUB_LOGIC_MV 8'h02
`define DHWIO_SUB_BOARD_TEMP 8'h03
`define DHWIO_SUB_MOTOR_TEMP 8'h04
`define DHWIO_SUB_CHIP_TEMP 8'h05
`define DHWIO_SUB_MODE_CFG 8'h01
`define DHWIO_SUB_VSWITCH 8'h02

// highest supported subindex of each object
`define DHWIO_CNT_HW_INFO 8'h01
`define DHWIO_CNT_HW_CONFIG 8'h01
`define DHWIO_CNT_OPER_COND 8'h05
`define DHWIO_CNT_SPECIAL 8'h02

// reset values
`define DHWIO_RST_EEPROM_CAP 32'h00000000
`define DHWIO_RST_HW_CONFIG 32'h00000000
`define DHWIO_RST_COND 32'h00000000
`define DHWIO_RST_MODE_CFG 8'h01
`define DHWIO_RST_VSWITCH 8'h00

// special-mode configuration codes
`define DHWIO_MODE_OFF 8'h00
`define DHWIO_MODE_ROTARY 8'h01
`define DHWIO_MODE_VIRTUAL 8'h02

`endif

// [verification/dhwio_bank_sva.sv]
// checker for the drive hardware information bank
// assumes it is bound to dhwio_bank and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module dhwio_bank_sva #(
	parameter ROTARY_W = 4
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [25:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic [31:0] eeprom_byte_capacity_in,
	input wire logic [31:0] power_stage_supply_mv_in,
	input wire logic [31:0] logic_supply_mv_in,
	input wire logic [31:0] board_temperature_in,
	input wire logic [ROTARY_W-1:0] rotary_switch_in,
	input wire logic [31:0] hw_config_out,
	input wire logic special_modes_enable_out,
	input wire logic [7:0] special_mode_select_out
);
	logic up_ff = 1'b0;
	always @(posedge clk_sys_in) up_ff <= !reset_in;
	wire req = wb_cyc_in && wb_stb_in && !wb_ack_out && up_ff;
	wire rd = req && !wb_we_in;
	wire wr = req && wb_we_in;
	wire [23:0] wa = wb_adr_in[25:2];
	wire cfg_wr = wr && wa == 24'h401501 && wb_sel_in[0];
	wire [7:0] cv = wb_dat_in[7:0];
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	ack_once_a: assert property (req |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not a single pulse");
	ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in && !wb_ack_out))
		else $error("ack without request");
	eeprom_read_a: assert property (rd && wa == 24'h401201 && $stable(eeprom_byte_capacity_in)
		|=> wb_dat_out == $past(eeprom_byte_capacity_in)) else $error("eeprom size wrong");
	supply_read_a: assert property (rd && wa == 24'h401401 && $stable(power_stage_supply_mv_in)
		|=> wb_dat_out == $past(power_stage_supply_mv_in)) else $error("supply wrong");
	temp_read_a: assert property (rd && wa == 24'h401403 && $stable(board_temperature_in)
		|=> wb_dat_out == $past(board_temperature_in)) else $error("temperature wrong");
	reserved_zero_a: assert property (rd && (wa == 24'h401404 || wa == 24'h401405)
		|=> wb_dat_out == 32'h00000000) else $error("reserved entry not zero");
	mode_off_a: assert property (cfg_wr && cv != 8'h01 && cv != 8'h02
		|-> ##2 !special_modes_enable_out && special_mode_select_out == 8'h00) else $error("mode on");
	mode_rotary_a: assert property (cfg_wr && cv == 8'h01 |-> ##2 special_modes_enable_out
		&& special_mode_select_out == $past(rotary_switch_in)) else $error("rotary mode wrong");
	mode_virtual_a: assert property (cfg_wr && cv == 8'h02
		|-> ##2 special_modes_enable_out) else $error("virtual mode off");
	hw_config_a: assert property (wr && wa == 24'h401301 && wb_sel_in == 4'hF
		|-> ##2 hw_config_out == $past(wb_dat_in, 2)) else $error("config word wrong");
	reset_clear_a: assert property (disable iff (1'b0) reset_in
		|=> !wb_ack_out && hw_config_out == 32'h00000000) else $error("reset not cleared");
	cover property (cfg_wr);
	cover property (rd && wa == 24'h401404);
	cover property (special_modes_enable_out && special_mode_select_out == 8'h07);
endmodule
bind dhwio_bank dhwio_bank_sva #(.ROTARY_W(ROTARY_W)) u_sva (.clk_sys_in(clk_sys_in),
	.reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
	.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
	.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.eeprom_byte_capacity_in(eeprom_byte_capacity_in),
	.power_stage_supply_mv_in(power_stage_supply_mv_in),
	.logic_supply_mv_in(logic_supply_mv_in), .board_temperature_in(board_temperature_in),
	.rotary_switch_in(rotary_switch_in), .hw_config_out(hw_config_out),
	.special_modes_enable_out(special_modes_enable_out),
	.special_mode_select_out(special_mode_select_out));
`default_nettype wire

// [verification/drive_hw_info_objects_test.sv]
// self-checking bench for the drive hardware information bank
// assumes dhwio_bank with a one-cycle wishbone ack
`timescale 1ns/1ps
`default_nettype none
module drive_hw_info_objects_test;
	logic clk_sys_in = 1'b0, reset_in = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [25:0] adr = 26'h0;
	logic [3:0] sel = 4'h0, rot = 4'h9;
	logic [31:0] di = 32'h0, ee = 32'h8000, pw = 32'hFFFFA240, lg = 32'h5DC0, bt = 32'hFA, q;
	wire [31:0] dq, hwo;
	wire ack, en;
	wire [7:0] ms;
	int n_errors = 0, n_compared = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	dhwio_bank #(.ROTARY_W(4)) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
		.wb_dat_in(di), .wb_dat_out(dq), .wb_ack_out(ack), .eeprom_byte_capacity_in(ee),
		.power_stage_supply_mv_in(pw), .logic_supply_mv_in(lg), .board_temperature_in(bt),
		.rotary_switch_in(rot), .hw_config_out(hwo), .special_modes_enable_out(en),
		.special_mode_select_out(ms));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [23:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_sys_in);
		{cyc, stb, we, adr, sel, di} <= {2'b11, w, a, 2'b00, s, d};
		do @(posedge clk_sys_in); while (ack !== 1'b1);
		q = dq;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rdc(input logic [23:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'h0);
		chk(q, e);
	endtask
	task automatic t_presets;
		rdc(24'h401501, 32'h1);
		rdc(24'h401502, 32'h0);
		rdc(24'h401301, 32'h0);
		chk(en, 1'b1);
		chk(ms, {4'h0, rot});
		// highest supported subindex of each object
		rdc(24'h401200, 32'h1);
		rdc(24'h401300, 32'h1);
		rdc(24'h401400, 32'h5);
		rdc(24'h401500, 32'h2);
	endtask
	task automatic t_meas;
		rdc(24'h401201, ee);
		wb(1'b1, 24'h401201, 32'hFFFFFFFF, 4'hF);
		rdc(24'h401201, ee);
		rdc(24'h401401, pw);
		rdc(24'h401402, lg);
		rdc(24'h401403, bt);
		rdc(24'h401404, 32'h0);
		rdc(24'h401405, 32'h0);
		ee <= 32'h0;
		rdc(24'h401201, 32'h0);
		rdc(24'h401600, 32'h0);
	endtask
	task automatic t_hw;
		wb(1'b1, 24'h401301, 32'hA5A55A5A, 4'hF);
		rdc(24'h401301, 32'hA5A55A5A);
		chk(hwo, 32'hA5A55A5A);
		wb(1'b1, 24'h401301, 32'h0, 4'h1);
		rdc(24'h401301, 32'hA5A55A00);
	endtask
	task automatic t_mode;
		int m;
		wb(1'b1, 24'h401502, 32'h7, 4'h1);
		for (m = 0; m < 4; m++) begin
			wb(1'b1, 24'h401501, 32'(m), 4'h1);
			rdc(24'h401501, 32'(m));
			chk(en, m == 1 || m == 2);
			chk(ms, m == 1 ? {4'h0, rot} : m == 2 ? 8'h07 : 8'h00);
		end
	endtask
	task automatic print_verdict;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		t_presets;
		t_meas;
		t_hw;
		t_mode;
		print_verdict;
	end
	initial begin
		#20000;
		n_errors++;
		print_verdict;
	end
endmodule
`default_nettype wire
